// >>> hw/rst_seq_pkg.sv
package rst_seq_pkg;

	// clock of the sequencer, in MHz (period 25 ns)
	localparam int CLK_MHZ = 40;

	// least width of any reset source that is safe mid external access, in ns; the watchdog reset here lasts one cycle
	localparam int MIN_RESET_NS = 2000;
	// least reset width rounds up to whole cycles
	localparam int MIN_RESET_CYC = (MIN_RESET_NS * CLK_MHZ + 999) / 1000;

	// power-on warm-up must exceed the least width
	localparam int WARMUP_CYC = MIN_RESET_CYC + 1;

	// watchdog counter width and the count that ends the wake-up delay
	localparam int WDOG_W = 12;
	localparam logic [WDOG_W-1:0] WAKE_DELAY_CNT = 12'hfff;

	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

	localparam logic [15:0] RESET_VECTOR = 16'h0000;

	typedef enum logic [2:0] {
		SEQ_RESET,
		SEQ_FIRST_FETCH,
		SEQ_RUN,
		SEQ_STOP,
		SEQ_WAKE
	} seq_state_e;

	// what the core sees from the sequencer
	typedef struct packed {
		logic        coreReset;
		logic        coreRun;
		logic        fetchVector;
		logic [15:0] fetchAddr;
		logic        abortAccess;
	} core_ctl_s;

endpackage

// >>> hw/reset_stretch.sv
`timescale 1ns/1ps
`default_nettype none
// counts a reset interval down; load starts a fresh interval from loadCount
module reset_stretch
	import rst_seq_pkg::*;
(
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] loadCount,
	output logic                  active
);
	logic [CNT_W-1:0] count;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			count <= CNT_ZERO;
		end else if (load) begin
			count <= loadCount;
		end else if (count != CNT_ZERO) begin
			count <= count - CNT_W'(1);
		end
	end

	assign active = (count != CNT_ZERO);
endmodule
`default_nettype wire

// >>> hw/reset_and_stop_exit_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module reset_and_stop_exit_sequencer
	import rst_seq_pkg::*;
(
	input  wire logic  clk_sys,
	input  wire logic  rst,
	input  wire logic  powerOnReset,
	input  wire logic  extReset,
	input  wire logic  watchdogTimeout,
	input  wire logic  watchdogResetEnable,
	input  wire logic  watchdog_restart_bit,
	input  wire logic  stopRequest,
	input  wire logic  wakeEvent,
	input  wire logic  external_data_move,
	input  wire logic  fetchDone,
	output core_ctl_s  coreCtl,
	output logic       strobeStrongDrive,
	output logic       watchdogResetPulse
);
	seq_state_e       state;
	seq_state_e       next_state;
	logic [WDOG_W-1:0] wdogCount;
	logic             porLoad;
	logic             porActive;
	logic             wdogFire;
	logic             wdogFirePrev;
	logic             abortPulse;
	logic             porPending;
	logic [CNT_W-1:0]  resetRun;

	// only the rising edge counts, so a held timeout cannot stretch reset
	assign wdogFire = watchdogTimeout & watchdogResetEnable & ~wdogFirePrev;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wdogFirePrev <= 1'b0;
		end else begin
			wdogFirePrev <= watchdogTimeout & watchdogResetEnable;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			watchdogResetPulse <= 1'b0;
		end else begin
			watchdogResetPulse <= wdogFire;
		end
	end

	assign porLoad = powerOnReset;

	reset_stretch warmup (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.load      (porLoad),
		.loadCount (CNT_W'(WARMUP_CYC)),
		.active    (porActive)
	);

	// watchdog counter doubles as the wake-up delay timer
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wdogCount <= '0;
		end else if (watchdog_restart_bit) begin
			wdogCount <= '0;
		end else if (state != SEQ_STOP) begin
			wdogCount <= wdogCount + WDOG_W'(1);
		end
	end

	function automatic logic anyReset(input logic por, input logic ext, input logic wd);
		anyReset = por | ext | wd;
	endfunction

	always_comb begin
		next_state = state;
		case (state)
			SEQ_RESET: begin
				if (!anyReset(porActive | porLoad, extReset, wdogFire)) begin
					next_state = SEQ_FIRST_FETCH;
				end
			end
			SEQ_FIRST_FETCH: begin
				if (fetchDone) begin
					next_state = SEQ_RUN;
				end
			end
			SEQ_RUN: begin
				if (stopRequest) begin
					next_state = SEQ_STOP;
				end
			end
			SEQ_STOP: begin
				if (wakeEvent) begin
					next_state = SEQ_WAKE;
				end
			end
			SEQ_WAKE: begin
				// count must climb to the full value, hence restart before stop
				if (wdogCount == WAKE_DELAY_CNT) begin
					next_state = SEQ_RUN;
				end
			end
			default: begin
				next_state = SEQ_RESET;
			end
		endcase
		if (anyReset(porLoad, extReset, wdogFire)) begin
			next_state = SEQ_RESET;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state <= SEQ_RESET;
		end else begin
			state <= next_state;
		end
	end

	// abort an in-flight external move the moment any reset lands
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			abortPulse <= 1'b0;
		end else begin
			abortPulse <= external_data_move & anyReset(porLoad, extReset, wdogFire);
		end
	end

	// one process drives the whole bundle, so no field has two writers
	always_comb begin
		coreCtl.coreReset   = (state == SEQ_RESET);
		coreCtl.coreRun     = (state == SEQ_RUN) || (state == SEQ_FIRST_FETCH);
		coreCtl.fetchVector = (state == SEQ_FIRST_FETCH);
		coreCtl.fetchAddr   = RESET_VECTOR;
		coreCtl.abortAccess = abortPulse;
	end
	// strong drivers every first fetch, regardless of reset length
	assign strobeStrongDrive   = (state == SEQ_FIRST_FETCH);

	// the 2 us external width is relied on, not checked; the sequencer holds reset
	// for however long extReset stays high

	// length of the running reset interval, saturating so a long hold cannot wrap
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			resetRun <= CNT_ZERO;
		end else if (state != SEQ_RESET) begin
			resetRun <= CNT_ZERO;
		end else if (resetRun != '1) begin
			resetRun <= resetRun + CNT_W'(1);
		end
	end

	// remembers a power-on event until its first fetch; a new event wins over the clear
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			porPending <= 1'b0;
		end else if (powerOnReset) begin
			porPending <= 1'b1;
		end else if (state == SEQ_FIRST_FETCH) begin
			porPending <= 1'b0;
		end
	end

	property wakeHeld;
		@(posedge clk_sys) disable iff (rst)
		(state == SEQ_WAKE && wdogCount != WAKE_DELAY_CNT && !extReset && !porLoad && !wdogFire)
			|=> (state == SEQ_WAKE);
	endproperty
	wake_delay_a: assert property (wakeHeld) else $error("wake left before delay");

	restart_clears_a: assert property (@(posedge clk_sys) disable iff (rst)
		watchdog_restart_bit |=> (wdogCount == '0)) else $error("restart did not clear");

	wdog_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
		watchdogResetPulse |=> !watchdogResetPulse) else $error("watchdog pulse stretched");

	sequence porSeen;
		powerOnReset ##1 !powerOnReset;
	endsequence
	por_stretch_a: assert property (@(posedge clk_sys) disable iff (rst)
		porSeen |-> coreCtl.coreReset [*8]) else $error("power-on reset too short");

	por_width_a: assert property (@(posedge clk_sys) disable iff (rst)
		($fell(coreCtl.coreReset) && porPending) |-> (resetRun > CNT_W'(MIN_RESET_CYC)))
		else $error("power-on reset not stretched");

	first_vector_a: assert property (@(posedge clk_sys) disable iff (rst)
		(state == SEQ_RESET && next_state == SEQ_FIRST_FETCH) |=>
			(coreCtl.fetchVector && coreCtl.fetchAddr == RESET_VECTOR)) else $error("first fetch not at vector");

	strong_strobe_a: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(coreCtl.coreReset) |-> (strobeStrongDrive && coreCtl.fetchVector)) else $error("strobe weak on first fetch");

	strobe_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		(coreCtl.fetchVector && !fetchDone && !anyReset(porLoad, extReset, wdogFire)) |=>
			strobeStrongDrive) else $error("strobe dropped before fetch");

	sequence wdogOnly;
		(wdogFire && !extReset && !porLoad && !porActive)
			##1 (!extReset && !porLoad && !wdogFire);
	endsequence
	wdog_short_a: assert property (@(posedge clk_sys) disable iff (rst)
		wdogOnly |=> !coreCtl.coreReset) else $error("watchdog reset stretched");

	stop_held_a: assert property (@(posedge clk_sys) disable iff (rst)
		(state == SEQ_STOP && !wakeEvent && !anyReset(porLoad, extReset, wdogFire)) |=>
			!coreCtl.coreRun) else $error("core ran during stop");

	abort_move_a: assert property (@(posedge clk_sys) disable iff (rst)
		(external_data_move && extReset) |=> (coreCtl.abortAccess && coreCtl.coreReset)) else $error("move not aborted");

	reset_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		extReset |=> coreCtl.coreReset) else $error("reset not held");
endmodule
`default_nettype wire

// >>> test/ext_reset_src.sv
`timescale 1ns/1ps
`default_nettype none
module ext_reset_src
	import rst_seq_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic go,
	output logic      extReset
);
	int left = 0;
	// a kick always yields the full safe width, never a short glitch
	always @(posedge clk_sys) begin
		if (go && left == 0)
			left <= MIN_RESET_CYC;
		else if (left > 0)
			left <= left - 1;
	end
	assign extReset = (left > 0);
endmodule
`default_nettype wire

// >>> test/tb_reset_and_stop_exit_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_reset_and_stop_exit_sequencer;
	import rst_seq_pkg::*;
	logic clk_sys = 0, rst = 1, powerOnReset = 0, watchdogTimeout = 0, watchdogResetEnable = 0;
	logic watchdog_restart_bit = 0, stopRequest = 0, wakeEvent = 0, external_data_move = 0;
	logic fetchDone = 0, go = 0, extReset, strobeStrongDrive, watchdogResetPulse;
	core_ctl_s coreCtl;
	int n_errors = 0, comparisons = 0, n, a, b, c, mv;
	initial forever #12.5 clk_sys = ~clk_sys;
	ext_reset_src i_ext_reset_src(.clk_sys, .go, .extReset);
	reset_and_stop_exit_sequencer i_reset_and_stop_exit_sequencer(.clk_sys, .rst, .powerOnReset, .extReset,
		.watchdogTimeout, .watchdogResetEnable, .watchdog_restart_bit, .stopRequest, .wakeEvent,
		.external_data_move, .fetchDone, .coreCtl, .strobeStrongDrive, .watchdogResetPulse);
	// safe reset width in cycles of 25 ns
	function int safeCyc();
		return 2000 / 25;
	endfunction
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task end_of_test();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task run_until(input int lim);
		a = 0;
		b = 0;
		c = 0;
		n = 0;
		while (coreCtl.fetchVector !== 1'b1) begin
			n++;
			if (n > lim) begin
				n_errors++;
				end_of_test();
			end
			a += watchdogResetPulse;
			b += coreCtl.coreReset;
			c += coreCtl.abortAccess;
			// the core gives up an aborted move
			if (coreCtl.abortAccess === 1'b1)
				external_data_move = 0;
			cyc(1);
		end
	endtask
	task fetch();
		chk(coreCtl.fetchAddr, 16'h0000);
		chk(strobeStrongDrive, 1'b1);
		fetchDone = 1;
		cyc(1);
		fetchDone = 0;
		chk({coreCtl.coreRun, coreCtl.fetchVector}, 2'b10);
	endtask
	initial begin
		void'($urandom(32'h681848a2));
		cyc(4);
		rst = 0;
		run_until(4);
		fetch();
		powerOnReset = 1;
		cyc($urandom_range(1, 9));
		powerOnReset = 0;
		run_until(200);
		chk(b > safeCyc() && b < safeCyc() + 4, 1'b1);
		fetch();
		watchdogResetEnable = 1;
		watchdogTimeout = 1;
		cyc(1);
		run_until(20);
		chk(a, 1);
		chk(b, 1);
		watchdogTimeout = 0;
		fetch();
		for (int i = 0; i < 6; i++) begin
			mv = $urandom_range(0, 1);
			external_data_move = mv[0];
			cyc($urandom_range(1, 20));
			go = 1;
			cyc(1);
			go = 0;
			run_until(300);
			external_data_move = 0;
			chk(b >= safeCyc(), 1'b1);
			chk(c, mv);
			fetch();
		end
		watchdog_restart_bit = 1;
		cyc(1);
		watchdog_restart_bit = 0;
		stopRequest = 1;
		cyc(1);
		stopRequest = 0;
		cyc($urandom_range(1, 5));
		chk(coreCtl.coreRun, 1'b0);
		wakeEvent = 1;
		cyc(1);
		wakeEvent = 0;
		n = 0;
		while (coreCtl.coreRun !== 1'b1 && n < 5000) begin
			n++;
			cyc(1);
		end
		// cleared counter must run the whole 12-bit span before resuming
		chk(n >= 4095 && n <= 4098, 1'b1);
		end_of_test();
	end
endmodule
`default_nettype wire
